// >>> shared/qei_regs_pkg.sv
/*
 * Package for the wide counter register set: register byte addresses, word
 * widths, compare modes and the carrier structs shared by the modules.
 * Assumes a 32-bit AXI4-Lite register bus with one word per register.
 */
package qei_regs_pkg;

    // register byte addresses, one aligned word each
    localparam logic [5:0] ADDR_INDEX_HIGH   = 6'h00;
    localparam logic [5:0] ADDR_INDEX_LOW    = 6'h04;
    localparam logic [5:0] ADDR_INDEX_HOLD   = 6'h08;
    localparam logic [5:0] ADDR_INIT_HIGH    = 6'h0c;
    localparam logic [5:0] ADDR_INIT_LOW     = 6'h10;
    localparam logic [5:0] ADDR_LE_HIGH      = 6'h14;
    localparam logic [5:0] ADDR_LE_LOW       = 6'h18;
    localparam logic [5:0] ADDR_GE_HIGH      = 6'h1c;
    localparam logic [5:0] ADDR_GE_LOW       = 6'h20;
    localparam logic [5:0] ADDR_TIMER_HIGH   = 6'h24;
    localparam logic [5:0] ADDR_TIMER_LOW    = 6'h28;
    localparam logic [5:0] ADDR_THOLD_HIGH   = 6'h2c;
    localparam logic [5:0] ADDR_THOLD_LOW    = 6'h30;
    localparam logic [5:0] ADDR_CONTROL      = 6'h34;
    localparam logic [5:0] ADDR_POSITION     = 6'h38;

    localparam int         WORD_W            = 16;
    localparam int         WIDE_W            = 32;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [31:0] WIDE_RESET       = 32'h00000000;

    // control word fields: compare mode, timer run
    localparam int         CTL_MODE_LSB      = 0;
    localparam int         CTL_TIMER_RUN     = 2;

    // compare output modes
    typedef enum logic [1:0]
    {
        CMP_OFF = 2'h0,
        CMP_GE  = 2'h1,
        CMP_LE  = 2'h2,
        CMP_RSV = 2'h3
    } cmp_mode_t;

    // one register access seen by the register file
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [5:0]  waddr;
        logic [5:0]  raddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } reg_access_t;

    // thresholds handed to the comparator
    typedef struct packed
    {
        cmp_mode_t   mode;
        logic [31:0] le_threshold;
        logic [31:0] ge_threshold;
    } cmp_config_t;

endpackage

// >>> verilog/qei_compare_out.sv
/*
 * Compare output: drives the compare pin from the position count and
 * the two thresholds, registered so the pin never glitches.
 * Assumes the position count is synchronous to CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module qei_compare_out
    import qei_regs_pkg::*;
(
    input  wire logic        clk,            // system clock
    input  wire logic        rst,            // synchronous reset
    input  wire cmp_config_t cfg,            // mode and thresholds
    input  wire logic [31:0] position_count, // live position count
    output logic             pin             // compare output pin
);
    typedef struct packed
    {
        logic pin;
    } cmp_state_t;

    cmp_state_t state;
    cmp_state_t next_state;

    // pin level from the selected comparison
    always_comb
    begin
        next_state = state;
        case (cfg.mode)
            CMP_GE:  next_state.pin = (position_count >= cfg.ge_threshold);
            CMP_LE:  next_state.pin = (position_count <= cfg.le_threshold);
            default: next_state.pin = 1'b0;
        endcase
        if (rst)
        begin
            next_state.pin = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        state <= next_state;
    end

    assign pin = state.pin;
endmodule // qei_compare_out
`default_nettype wire

// >>> verilog/qei_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either
 * order, one write and one read at a time, and hands single-cycle
 * access strobes to the register file. Assumes a 32-bit bus.
 */
`timescale 1ns/1ps
`default_nettype none
module qei_axil_slave
    import qei_regs_pkg::*;
(
    input  wire logic        clk,     // system clock
    input  wire logic        rst,     // synchronous reset
    input  wire logic [5:0]  awaddr,  // write address
    input  wire logic        awvalid, // write address valid
    output logic             awready, // write address ready
    input  wire logic [31:0] wdata,   // write data
    input  wire logic [3:0]  wstrb,   // write strobes
    input  wire logic        wvalid,  // write data valid
    output logic             wready,  // write data ready
    output logic             bvalid,  // write response valid
    input  wire logic        bready,  // write response ready
    input  wire logic [5:0]  araddr,  // read address
    input  wire logic        arvalid, // read address valid
    output logic             arready, // read address ready
    output logic             rvalid,  // read data valid
    input  wire logic        rready,  // read data ready
    output reg_access_t      acc      // access strobes to registers
);
    typedef struct packed
    {
        logic        aw_got;
        logic        w_got;
        logic        bvalid;
        logic        rvalid;
        logic [5:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } axi_state_t;

    axi_state_t state;
    axi_state_t next_state;
    logic       do_write;
    logic       do_read;

    // channel readies: hold off until the previous response is taken
    assign awready  = !state.aw_got && !state.bvalid;
    assign wready   = !state.w_got && !state.bvalid;
    assign arready  = !state.rvalid;
    assign do_read  = arvalid && arready;
    assign do_write = (state.aw_got || (awvalid && awready))
                   && (state.w_got || (wvalid && wready));

    always_comb
    begin
        next_state = state;
        if (awvalid && awready)
        begin
            next_state.aw_got = 1'b1;
            next_state.waddr  = awaddr;
        end
        if (wvalid && wready)
        begin
            next_state.w_got = 1'b1;
            next_state.wdata = wdata;
            next_state.wstrb = wstrb;
        end
        if (do_write)
        begin
            next_state.aw_got = 1'b0;
            next_state.w_got  = 1'b0;
            next_state.bvalid = 1'b1;
        end
        else if (state.bvalid && bready)
        begin
            next_state.bvalid = 1'b0;
        end
        if (do_read)
        begin
            next_state.rvalid = 1'b1;
        end
        else if (state.rvalid && rready)
        begin
            next_state.rvalid = 1'b0;
        end
        if (rst)
        begin
            next_state = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        state <= next_state;
    end

    // strobes carry the freshest address and data, stored or on the bus
    always_comb
    begin
        acc.wr    = do_write && !rst;
        acc.rd    = do_read && !rst;
        acc.raddr = araddr;
        acc.waddr = state.aw_got ? state.waddr : awaddr;
        acc.wdata = state.w_got ? state.wdata : wdata;
        acc.wstrb = state.w_got ? state.wstrb : wstrb;
    end

    assign bvalid = state.bvalid;
    assign rvalid = state.rvalid;
endmodule // qei_axil_slave
`default_nettype wire

// >>> verilog/qei_wide_counter_registers.sv
/*
 * Wide counter register set of the encoder interface: index counter
 * with its hold word, init/capture value, the two compare thresholds,
 * and the interval timer with its two hold words, behind AXI4-Lite.
 * Assumes the encoder decoder supplies the position count and index
 * pulses synchronous to CLK; each 32-bit value but the position count shows as two words.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
// How it works
// - The index counter is one 32-bit value shown as a high and a low word.
// - A 16-bit hold word stages the upper index count half for software.
// - The init/capture value is 32 bits, written and read as two words.
// - The less-or-equal threshold is 32 bits formed from two words.
// - The greater-or-equal threshold is 32 bits formed from two words.
// - The interval timer is 32 bits shown as a high and a low word.
// - A hold word stages the timer's upper half for software access.
// - A hold word stages the timer's lower half for software access.
// - All these registers are read/write and clear to zero on reset.
// - In mode one the compare pin is high while position >= ge threshold.
// - In mode two the compare pin is high while position <= le threshold.
`timescale 1ns/1ps
`default_nettype none
module qei_wide_counter_registers
    import qei_regs_pkg::*;
(
    input  wire logic        CLK,            // 100 MHz system clock
    input  wire logic        SYS_RST,        // synchronous reset, high
    input  wire logic [31:0] POSITION_COUNT, // position count from decoder
    input  wire logic        INDEX_PULSE,    // one-cycle index event
    input  wire logic        CAPTURE_PULSE,  // one-cycle capture event
    output logic             COMPARE_PIN,    // compare output pin
    input  wire logic [5:0]  S_AWADDR,       // write address
    input  wire logic        S_AWVALID,      // write address valid
    output logic             S_AWREADY,      // write address ready
    input  wire logic [31:0] S_WDATA,        // write data
    input  wire logic [3:0]  S_WSTRB,        // write byte strobes
    input  wire logic        S_WVALID,       // write data valid
    output logic             S_WREADY,       // write data ready
    output logic [1:0]       S_BRESP,        // write response
    output logic             S_BVALID,       // write response valid
    input  wire logic        S_BREADY,       // write response ready
    input  wire logic [5:0]  S_ARADDR,       // read address
    input  wire logic        S_ARVALID,      // read address valid
    output logic             S_ARREADY,      // read address ready
    output logic [31:0]      S_RDATA,        // read data
    output logic [1:0]       S_RRESP,        // read response
    output logic             S_RVALID,       // read data valid
    input  wire logic        S_RREADY        // read data ready
);
    typedef struct packed
    {
        logic [31:0] index_counter;
        logic [15:0] index_count_staging;
        logic [31:0] init_capture_reg;
        logic [31:0] le_threshold;
        logic [31:0] ge_threshold;
        logic [31:0] interval_timer;
        logic [15:0] thold_high;
        logic [15:0] thold_low;
        logic [2:0]  control;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
    } regs_state_t;

    regs_state_t state;
    regs_state_t next_state;
    reg_access_t acc;
    cmp_config_t cmp_cfg;

    // merge the low half of a bus word into one 16-bit word by strobes
    function automatic logic [15:0] merge_word(
        input logic [15:0] old_value,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] result;
        result = old_value;
        if (strb[0])
        begin
            result[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // true when the address hits one of the mapped words
    function automatic logic addr_mapped(input logic [5:0] addr);
        return addr[1:0] == 2'h0 && addr <= ADDR_POSITION;
    endfunction

    qei_axil_slave u_bus
    (
        .clk     (CLK),
        .rst     (SYS_RST),
        .awaddr  (S_AWADDR),
        .awvalid (S_AWVALID),
        .awready (S_AWREADY),
        .wdata   (S_WDATA),
        .wstrb   (S_WSTRB),
        .wvalid  (S_WVALID),
        .wready  (S_WREADY),
        .bvalid  (S_BVALID),
        .bready  (S_BREADY),
        .araddr  (S_ARADDR),
        .arvalid (S_ARVALID),
        .arready (S_ARREADY),
        .rvalid  (S_RVALID),
        .rready  (S_RREADY),
        .acc     (acc)
    );

    // counter, timer and bus writes; a software write wins over an
    // event in the same cycle so the written value is what software sees
    always_comb
    begin
        next_state = state;

        // hardware side: index events, capture, timer run
        if (INDEX_PULSE)
        begin
            next_state.index_counter = state.index_counter + 32'h1;
        end
        if (CAPTURE_PULSE)
        begin
            next_state.init_capture_reg = POSITION_COUNT;
        end
        if (state.control[CTL_TIMER_RUN])
        begin
            next_state.interval_timer = state.interval_timer + 32'h1;
        end

        // read side: data is registered for the R channel
        if (acc.rd)
        begin
            next_state.rresp = addr_mapped(acc.raddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
            next_state.rdata = WIDE_RESET;
            case (acc.raddr)
                ADDR_INDEX_HIGH: next_state.rdata[15:0] =
                                     state.index_counter[31:16];
                ADDR_INDEX_LOW:
                begin
                    next_state.rdata[15:0] = state.index_counter[15:0];
                    next_state.index_count_staging =
                        state.index_counter[31:16];
                end
                ADDR_INDEX_HOLD: next_state.rdata[15:0] =
                                     state.index_count_staging;
                ADDR_INIT_HIGH:  next_state.rdata[15:0] =
                                     state.init_capture_reg[31:16];
                ADDR_INIT_LOW:   next_state.rdata[15:0] =
                                     state.init_capture_reg[15:0];
                ADDR_LE_HIGH:    next_state.rdata[15:0] =
                                     state.le_threshold[31:16];
                ADDR_LE_LOW:     next_state.rdata[15:0] =
                                     state.le_threshold[15:0];
                ADDR_GE_HIGH:    next_state.rdata[15:0] =
                                     state.ge_threshold[31:16];
                ADDR_GE_LOW:     next_state.rdata[15:0] =
                                     state.ge_threshold[15:0];
                ADDR_TIMER_HIGH: next_state.rdata[15:0] =
                                     state.interval_timer[31:16];
                ADDR_TIMER_LOW:
                begin
                    next_state.rdata[15:0] = state.interval_timer[15:0];
                    next_state.thold_high =
                        state.interval_timer[31:16];
                    next_state.thold_low  =
                        state.interval_timer[15:0];
                end
                ADDR_THOLD_HIGH: next_state.rdata[15:0] = state.thold_high;
                ADDR_THOLD_LOW:  next_state.rdata[15:0] = state.thold_low;
                ADDR_CONTROL:    next_state.rdata[2:0]  = state.control;
                ADDR_POSITION:   next_state.rdata       = POSITION_COUNT;
                default:         next_state.rdata       = WIDE_RESET;
            endcase
        end

        // write side: all value words are read/write
        if (acc.wr)
        begin
            next_state.bresp = addr_mapped(acc.waddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
            case (acc.waddr)
                ADDR_INDEX_HIGH: next_state.index_counter[31:16] = merge_word(
                    state.index_counter[31:16], acc.wdata, acc.wstrb);
                ADDR_INDEX_LOW:  next_state.index_counter = {
                    state.index_count_staging, merge_word(
                    state.index_counter[15:0], acc.wdata, acc.wstrb)};
                ADDR_INDEX_HOLD: next_state.index_count_staging = merge_word(
                    state.index_count_staging, acc.wdata, acc.wstrb);
                ADDR_INIT_HIGH:  next_state.init_capture_reg[31:16] =
                    merge_word(state.init_capture_reg[31:16],
                               acc.wdata, acc.wstrb);
                ADDR_INIT_LOW:   next_state.init_capture_reg[15:0] =
                    merge_word(state.init_capture_reg[15:0],
                               acc.wdata, acc.wstrb);
                ADDR_LE_HIGH:    next_state.le_threshold[31:16] = merge_word(
                    state.le_threshold[31:16], acc.wdata, acc.wstrb);
                ADDR_LE_LOW:     next_state.le_threshold[15:0] = merge_word(
                    state.le_threshold[15:0], acc.wdata, acc.wstrb);
                ADDR_GE_HIGH:    next_state.ge_threshold[31:16] = merge_word(
                    state.ge_threshold[31:16], acc.wdata, acc.wstrb);
                ADDR_GE_LOW:     next_state.ge_threshold[15:0] = merge_word(
                    state.ge_threshold[15:0], acc.wdata, acc.wstrb);
                ADDR_TIMER_HIGH: next_state.interval_timer[31:16] =
                    merge_word(state.interval_timer[31:16],
                               acc.wdata, acc.wstrb);
                ADDR_TIMER_LOW:  next_state.interval_timer = {
                    state.thold_high, merge_word(state.interval_timer[15:0],
                    acc.wdata, acc.wstrb)};
                ADDR_THOLD_HIGH: next_state.thold_high = merge_word(
                    state.thold_high, acc.wdata, acc.wstrb);
                ADDR_THOLD_LOW:  next_state.thold_low = merge_word(
                    state.thold_low, acc.wdata, acc.wstrb);
                ADDR_CONTROL:
                begin
                    if (acc.wstrb[0])
                    begin
                        next_state.control = acc.wdata[2:0];
                    end
                end
                default:         next_state.bresp = RESP_SLVERR;
            endcase
        end

        // everything clears to zero on reset
        if (SYS_RST)
        begin
            next_state = '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        state <= next_state;
    end

    // the comparator only sees the registered thresholds and mode
    assign cmp_cfg.mode = cmp_mode_t'(state.control[CTL_MODE_LSB +: 2]);
    assign cmp_cfg.le_threshold = state.le_threshold;
    assign cmp_cfg.ge_threshold = state.ge_threshold;

    qei_compare_out u_cmp
    (
        .clk            (CLK),
        .rst            (SYS_RST),
        .cfg            (cmp_cfg),
        .position_count (POSITION_COUNT),
        .pin            (COMPARE_PIN)
    );

    assign S_RDATA = state.rdata;
    assign S_RRESP = state.rresp;
    assign S_BRESP = state.bresp;
endmodule // qei_wide_counter_registers
`default_nettype wire

// >>> tb/qei_regs_asserts.sv
/*
 * Checker for the wide counter register set: bus handshakes, response
 * timing and word shape at the top ports. Assumes the bind below.
 */
`timescale 1ns/1ps
`default_nettype none
module qei_regs_asserts
    import qei_regs_pkg::*;
(
    input wire logic        CLK,         // system clock
    input wire logic        SYS_RST,     // synchronous reset
    input wire logic        COMPARE_PIN, // compare output
    input wire logic        S_AWVALID,   // write address valid
    input wire logic        S_AWREADY,   // write address ready
    input wire logic        S_WVALID,    // write data valid
    input wire logic        S_WREADY,    // write data ready
    input wire logic [1:0]  S_BRESP,     // write response
    input wire logic        S_BVALID,    // write response valid
    input wire logic        S_BREADY,    // write response ready
    input wire logic [5:0]  S_ARADDR,    // read address
    input wire logic        S_ARVALID,   // read address valid
    input wire logic        S_ARREADY,   // read address ready
    input wire logic [31:0] S_RDATA,     // read data
    input wire logic [1:0]  S_RRESP,     // read response
    input wire logic        S_RVALID,    // read valid
    input wire logic        S_RREADY     // read ready
);
    logic [5:0] rd_addr;

    // remember the read address, only the position word is 32 bits wide
    always_ff @(posedge CLK)
    begin
        if (S_ARVALID && S_ARREADY)
            rd_addr <= S_ARADDR;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence ar_taken;
        S_ARVALID && S_ARREADY;
    endsequence
    sequence pair_taken;
        S_AWVALID && S_AWREADY && S_WVALID && S_WREADY;
    endsequence

    AST_RST_IDLE: assert property ($past(SYS_RST) |-> !S_BVALID
        && !S_RVALID && !COMPARE_PIN) else $error("outputs busy after reset");
    AST_B_NEXT: assert property (pair_taken |=> S_BVALID)
        else $error("write response late");
    AST_B_HOLD: assert property (S_BVALID && !S_BREADY |=> S_BVALID
        && $stable(S_BRESP)) else $error("write response dropped");
    AST_B_DONE: assert property (S_BVALID && S_BREADY |=> !S_BVALID)
        else $error("write response repeated");
    AST_B_REFUSE: assert property (S_BVALID |-> !S_AWREADY
        && !S_WREADY) else $error("write taken during response");
    AST_R_NEXT: assert property (ar_taken |=> S_RVALID)
        else $error("read data late");
    AST_R_HOLD: assert property (S_RVALID && !S_RREADY |=> S_RVALID
        && $stable(S_RDATA) && $stable(S_RRESP)) else $error("read dropped");
    AST_R_REFUSE: assert property (S_RVALID |-> !S_ARREADY)
        else $error("read taken during answer");
    AST_R_WORD: assert property (S_RVALID && rd_addr != ADDR_POSITION
        |-> S_RDATA[31:16] == 16'h0000) else $error("upper half not zero");
    AST_R_BAD: assert property (S_ARVALID && S_ARREADY
        && (S_ARADDR > ADDR_POSITION || S_ARADDR[1:0] != 2'h0)
        |=> S_RRESP == RESP_SLVERR && S_RDATA == 32'h00000000)
        else $error("unmapped read not refused");
endmodule // qei_regs_asserts

bind qei_wide_counter_registers qei_regs_asserts chk (.CLK, .SYS_RST,
    .COMPARE_PIN, .S_AWVALID, .S_AWREADY, .S_WVALID, .S_WREADY, .S_BRESP,
    .S_BVALID, .S_BREADY, .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA,
    .S_RRESP, .S_RVALID, .S_RREADY);
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Testbench for the wide counter register set: a table of register
 * accesses, then staging, counting, capture, compare and error tests.
 * Assumes the checker is bound to the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import qei_regs_pkg::*;
;
    typedef struct packed {logic [5:0] a; logic [15:0] v;} row_t;
    typedef struct packed {logic [1:0] m; logic [31:0] p; logic e;} crow_t;
    logic        clk, rst, idx_p, cap_p, pin, awv, awr, wv, wr_, bv, bre;
    logic        arv, arr, rv, rre, fa, fw, fb;
    logic [31:0] pos, wd, rdat, d;
    logic [5:0]  awa, ara;
    logic [3:0]  ws;
    logic [1:0]  br, rr, r;
    int          fails, total_checks, cycles;
    // the index low and timer low rows rely on the hold rows before them
    row_t rows [13] = '{'{ADDR_INDEX_HIGH, 16'ha5a5},
        '{ADDR_INDEX_HOLD, 16'h1234}, '{ADDR_INDEX_LOW, 16'hbeef},
        '{ADDR_INIT_HIGH, 16'h1111}, '{ADDR_INIT_LOW, 16'h2222},
        '{ADDR_LE_HIGH, 16'h3333}, '{ADDR_LE_LOW, 16'h4444},
        '{ADDR_GE_HIGH, 16'h5555}, '{ADDR_GE_LOW, 16'h6666},
        '{ADDR_TIMER_HIGH, 16'h9999}, '{ADDR_THOLD_HIGH, 16'h5a5a},
        '{ADDR_THOLD_LOW, 16'h0f0f}, '{ADDR_TIMER_LOW, 16'h3c3c}};
    crow_t crows [6] = '{'{2'h1, 32'h0000ffff, 1'b0},
        '{2'h1, 32'h00010000, 1'b1}, '{2'h2, 32'h00000010, 1'b1},
        '{2'h2, 32'h00000011, 1'b0}, '{2'h0, 32'h00010000, 1'b0},
        '{2'h3, 32'h00000010, 1'b0}};

    qei_wide_counter_registers dut (.CLK(clk), .SYS_RST(rst),
        .POSITION_COUNT(pos), .INDEX_PULSE(idx_p), .CAPTURE_PULSE(cap_p),
        .COMPARE_PIN(pin), .S_AWADDR(awa), .S_AWVALID(awv), .S_AWREADY(awr),
        .S_WDATA(wd), .S_WSTRB(ws), .S_WVALID(wv), .S_WREADY(wr_),
        .S_BRESP(br), .S_BVALID(bv), .S_BREADY(bre), .S_ARADDR(ara),
        .S_ARVALID(arv), .S_ARREADY(arr), .S_RDATA(rdat), .S_RRESP(rr),
        .S_RVALID(rv), .S_RREADY(rre));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // a hung handshake ends the run as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wrc(input logic [5:0] a, input logic [31:0] v,
                       input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= v;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        forever
        begin
            @(negedge clk); // settled readies, no race with the edge
            {fa, fw, fb} = {awr, wr_, bv};
            @(posedge clk);
            if (fa)
                awv <= 1'b0;
            if (fw)
                wv <= 1'b0;
            if (fb)
                break;
        end
        bre <= 1'b0;
        check({30'h0, br}, {30'h0, er});
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        forever
        begin
            @(negedge clk);
            {fa, fb} = {arr, rv};
            @(posedge clk);
            if (fa)
                arv <= 1'b0;
            if (fb)
                break;
        end
        rre <= 1'b0;
        d = rdat;
        check(d, e);
        check({30'h0, rr}, {30'h0, er});
    endtask

    task automatic pulse(input logic which);
        @(posedge clk);
        idx_p <= which;
        cap_p <= !which;
        @(posedge clk);
        idx_p <= 1'b0;
        cap_p <= 1'b0;
    endtask

    initial
    begin
        {idx_p, cap_p, awv, wv, bre, arv, rre} = '0;
        {pos, wd, awa, ara, ws} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) rdc(rows[i].a, 32'h0, RESP_OKAY);
        $display("test reset values done");
        // upper write bits set on purpose, they must not stick
        foreach (rows[i])
        begin
            wrc(rows[i].a, {16'hffff, rows[i].v}, RESP_OKAY);
            rdc(rows[i].a, {16'h0, rows[i].v}, RESP_OKAY);
        end
        $display("test register table done");
        rdc(ADDR_INDEX_HIGH, 32'h1234, RESP_OKAY);
        rdc(ADDR_INDEX_HOLD, 32'h1234, RESP_OKAY);
        rdc(ADDR_TIMER_HIGH, 32'h5a5a, RESP_OKAY);
        rdc(ADDR_THOLD_HIGH, 32'h5a5a, RESP_OKAY);
        rdc(ADDR_THOLD_LOW, 32'h3c3c, RESP_OKAY);
        // carry out of the low half must reach the staged high half
        wrc(ADDR_INDEX_HOLD, 32'h0, RESP_OKAY);
        wrc(ADDR_INDEX_LOW, 32'hffff, RESP_OKAY);
        pulse(1'b1);
        rdc(ADDR_INDEX_LOW, 32'h0, RESP_OKAY);
        rdc(ADDR_INDEX_HOLD, 32'h1, RESP_OKAY);
        rdc(ADDR_INDEX_HIGH, 32'h1, RESP_OKAY);
        pos <= 32'h89abcdef;
        pulse(1'b0);
        rdc(ADDR_INIT_HIGH, 32'h89ab, RESP_OKAY);
        rdc(ADDR_INIT_LOW, 32'hcdef, RESP_OKAY);
        $display("test staging and capture done");
        wrc(ADDR_CONTROL, 32'h4, RESP_OKAY);
        repeat (20) @(posedge clk);
        wrc(ADDR_CONTROL, 32'h0, RESP_OKAY);
        rdc(ADDR_THOLD_LOW, 32'h3c3c, RESP_OKAY);
        rdc(ADDR_TIMER_LOW, 32'h3c53, RESP_OKAY);
        check(d > 32'h3c3c && d < 32'h3c6c, 32'h1);
        $display("test interval timer done");
        wrc(ADDR_GE_HIGH, 32'h1, RESP_OKAY);
        wrc(ADDR_GE_LOW, 32'h0, RESP_OKAY);
        wrc(ADDR_LE_HIGH, 32'h0, RESP_OKAY);
        wrc(ADDR_LE_LOW, 32'h10, RESP_OKAY);
        foreach (crows[i])
        begin
            wrc(ADDR_CONTROL, {30'h0, crows[i].m}, RESP_OKAY);
            pos <= crows[i].p;
            repeat (3) @(posedge clk);
            check({31'h0, pin}, {31'h0, crows[i].e});
        end
        $display("test compare pin done");
        rdc(6'h3c, 32'h0, RESP_SLVERR);
        rdc(6'h02, 32'h0, RESP_SLVERR);
        wrc(6'h3c, 32'h1, RESP_SLVERR);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_LE_LOW, 32'h0, RESP_OKAY);
        rdc(ADDR_INIT_HIGH, 32'h0, RESP_OKAY);
        $display("test errors and second reset done");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
